//--- fbpi_host_ctrl.sv
// Operation
// - Low lane carries commands and data in; read data comes back on it.
// - Device selected only while both chip selects are low.
// - Powerdown reset low enters deep power-down; wait 400 ns after release.
// - Device captures address and data on the write strobe rising edge.
// - Width select low gives x8 with high lane floating; high gives x16.
`timescale 1ns/1ps
`default_nettype none

module fbpi_host_ctrl
  import fbpi_pkg::*;
#(
  parameter int unsigned SETUP_CYCLES  = SETUP_CYCLES_DEF,
  parameter int unsigned STROBE_CYCLES = STROBE_CYCLES_DEF,
  parameter int unsigned HOLD_CYCLES   = HOLD_CYCLES_DEF
)
(
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              rst,
  // User command port
  input  wire logic              cmd_valid,
  input  wire logic              cmd_write,
  input  wire logic              cmd_byte_mode,
  input  wire logic [ADDR_W-1:0] cmd_addr,
  input  wire logic [DATA_W-1:0] cmd_wdata,
  output logic                   cmd_ready,
  output logic                   rsp_valid,
  output logic [DATA_W-1:0]      rsp_rdata,
  // User power and protection
  input  wire logic              powerdown_req,
  input  wire logic              write_protect_release,
  output logic                   device_ready,
  // Flash address pins
  output logic                   byte_lane_select,
  output logic [WORD_W-1:0]      word_address,
  output logic [BLOCK_W-1:0]     block_address,
  // Flash data lanes
  input  wire logic [LANE_W-1:0] low_data_lane_in,
  output logic [LANE_W-1:0]      low_data_lane_out,
  output logic                   low_data_lane_oe_n,
  input  wire logic [LANE_W-1:0] high_data_lane_in,
  output logic [LANE_W-1:0]      high_data_lane_out,
  output logic                   high_data_lane_oe_n,
  // Flash control pins
  output logic                   chip_select_a_n,
  output logic                   chip_select_b_n,
  output logic                   output_enable_n,
  output logic                   write_strobe_n,
  output logic                   powerdown_reset_n,
  output logic                   width_select,
  output logic                   write_protect_n,
  input  wire logic              ready_busy_pin
);

  // Parameter checks at elaboration
  if (SETUP_CYCLES < 1 || SETUP_CYCLES > (1 << TMR_W)) begin : gen_bad_setup
    $error("SETUP_CYCLES out of range");
  end
  if (STROBE_CYCLES < 1 || STROBE_CYCLES > (1 << TMR_W)) begin : gen_bad_strobe
    $error("STROBE_CYCLES out of range");
  end
  if (HOLD_CYCLES < 1 || HOLD_CYCLES > (1 << TMR_W)) begin : gen_bad_hold
    $error("HOLD_CYCLES out of range");
  end

  // Timer counts, one less than the phase length
  localparam logic [TMR_W-1:0] SETUP_LOAD   = TMR_W'(SETUP_CYCLES - 1);
  localparam logic [TMR_W-1:0] STROBE_LOAD  = TMR_W'(STROBE_CYCLES - 1);
  localparam logic [TMR_W-1:0] HOLD_LOAD    = TMR_W'(HOLD_CYCLES - 1);
  localparam logic [TMR_W-1:0] RECOVER_LOAD = TMR_W'(RECOVERY_CYCLES - 1);

  fbpi_timer_if tmr ();

  fbpi_phase_timer u_timer (
    .clock (clock),
    .rst   (rst),
    .tmr   (tmr)
  );

  fbpi_state_type       state_reg,   state_next;
  logic                 write_reg,   write_next;
  logic                 byte_reg,    byte_next;
  logic                 rdy_reg,     rdy_next;
  logic                 rsp_reg,     rsp_next;
  logic [DATA_W-1:0]    rdata_reg,   rdata_next;
  logic                 bsel_reg,    bsel_next;
  logic [WORD_W-1:0]    word_reg,    word_next;
  logic [BLOCK_W-1:0]   block_reg,   block_next;
  logic [LANE_W-1:0]    lo_out_reg,  lo_out_next;
  logic [LANE_W-1:0]    hi_out_reg,  hi_out_next;
  logic                 lo_oe_reg,   lo_oe_next;
  logic                 hi_oe_reg,   hi_oe_next;
  logic                 cs_reg,      cs_next;
  logic                 oe_reg,      oe_next;
  logic                 we_reg,      we_next;
  logic                 pd_reg,      pd_next;
  logic                 width_reg,   width_next;
  logic                 wp_reg,      wp_next;
  logic                 devrdy_reg,  devrdy_next;

  // Sequencer next state
  always_comb begin
    state_next  = state_reg;
    write_next  = write_reg;
    byte_next   = byte_reg;
    rdy_next    = rdy_reg;
    rsp_next    = 1'b0;
    rdata_next  = rdata_reg;
    bsel_next   = bsel_reg;
    word_next   = word_reg;
    block_next  = block_reg;
    lo_out_next = lo_out_reg;
    hi_out_next = hi_out_reg;
    lo_oe_next  = lo_oe_reg;
    hi_oe_next  = hi_oe_reg;
    cs_next     = cs_reg;
    oe_next     = oe_reg;
    we_next     = we_reg;
    pd_next     = pd_reg;
    width_next  = width_reg;
    tmr.load    = 1'b0;
    tmr.count   = '0;
    case (state_reg)
      ST_POWERDOWN: begin
        pd_next = 1'b0;
        if (!powerdown_req) begin
          pd_next    = 1'b1;
          tmr.load   = 1'b1;
          tmr.count  = RECOVER_LOAD;
          state_next = ST_RECOVER;
        end
      end
      ST_RECOVER: begin
        if (tmr.expired) begin
          rdy_next   = 1'b1;
          state_next = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (powerdown_req) begin
          rdy_next   = 1'b0;
          pd_next    = 1'b0;
          state_next = ST_POWERDOWN;
        end else if (cmd_valid) begin
          rdy_next   = 1'b0;
          write_next = cmd_write;
          byte_next  = cmd_byte_mode;
          width_next = !cmd_byte_mode;
          bsel_next  = cmd_byte_mode ? cmd_addr[BYTE_SEL_BIT] : 1'b0;
          word_next  = cmd_addr[WORD_LSB +: WORD_W];
          block_next = cmd_addr[BLOCK_LSB +: BLOCK_W];
          cs_next    = 1'b0;
          if (cmd_write) begin
            lo_out_next = cmd_byte_mode ? cmd_wdata[LANE_W-1:0]
                                        : cmd_wdata[LANE_W-1:0];
            lo_oe_next  = 1'b0;
            // high lane only in x16 writes
            hi_out_next = cmd_wdata[DATA_W-1:LANE_W];
            hi_oe_next  = cmd_byte_mode;
          end
          tmr.load   = 1'b1;
          tmr.count  = SETUP_LOAD;
          state_next = ST_SETUP;
        end
      end
      ST_SETUP: begin
        if (tmr.expired) begin
          // only one strobe low at a time
          if (write_reg) begin
            we_next = 1'b0;
          end else begin
            // device drives only with enable low
            oe_next = 1'b0;
          end
          tmr.load   = 1'b1;
          tmr.count  = STROBE_LOAD;
          state_next = ST_STROBE;
        end
      end
      ST_STROBE: begin
        if (tmr.expired) begin
          if (!write_reg) begin
            // x8 reads use the low lane only
            rdata_next = byte_reg ? {{LANE_W{1'b0}}, low_data_lane_in}
                                  : {high_data_lane_in, low_data_lane_in};
          end
          // rising strobe edge commits the write
          we_next    = 1'b1;
          oe_next    = 1'b1;
          tmr.load   = 1'b1;
          tmr.count  = HOLD_LOAD;
          state_next = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (tmr.expired) begin
          // deselect freely, device finishes its work
          cs_next    = 1'b1;
          lo_oe_next = 1'b1;
          hi_oe_next = 1'b1;
          rsp_next   = 1'b1;
          rdy_next   = 1'b1;
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_POWERDOWN;
      end
    endcase
  end

  // Protection and ready sampling
  always_comb begin
    wp_next     = write_protect_release;
    // pin high means ready; valid regardless of selects
    devrdy_next = ready_busy_pin && pd_reg && (state_reg != ST_RECOVER);
  end

  // Register all state and pins
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg  <= ST_POWERDOWN;
      write_reg  <= 1'b0;
      byte_reg   <= 1'b0;
      rdy_reg    <= 1'b0;
      rsp_reg    <= 1'b0;
      rdata_reg  <= '0;
      bsel_reg   <= 1'b0;
      word_reg   <= '0;
      block_reg  <= '0;
      lo_out_reg <= '0;
      hi_out_reg <= '0;
      lo_oe_reg  <= 1'b1;
      hi_oe_reg  <= 1'b1;
      cs_reg     <= 1'b1;
      oe_reg     <= 1'b1;
      we_reg     <= 1'b1;
      pd_reg     <= 1'b0;
      width_reg  <= 1'b1;
      wp_reg     <= 1'b0;
      devrdy_reg <= 1'b0;
    end else begin
      state_reg  <= state_next;
      write_reg  <= write_next;
      byte_reg   <= byte_next;
      rdy_reg    <= rdy_next;
      rsp_reg    <= rsp_next;
      rdata_reg  <= rdata_next;
      bsel_reg   <= bsel_next;
      word_reg   <= word_next;
      block_reg  <= block_next;
      lo_out_reg <= lo_out_next;
      hi_out_reg <= hi_out_next;
      lo_oe_reg  <= lo_oe_next;
      hi_oe_reg  <= hi_oe_next;
      cs_reg     <= cs_next;
      oe_reg     <= oe_next;
      we_reg     <= we_next;
      pd_reg     <= pd_next;
      width_reg  <= width_next;
      wp_reg     <= wp_next;
      devrdy_reg <= devrdy_next;
    end
  end

  // Outputs straight from flip-flops
  assign cmd_ready           = rdy_reg;
  assign rsp_valid           = rsp_reg;
  assign rsp_rdata           = rdata_reg;
  assign device_ready        = devrdy_reg;
  assign byte_lane_select    = bsel_reg;
  assign word_address        = word_reg;
  assign block_address       = block_reg;
  assign low_data_lane_out   = lo_out_reg;
  assign low_data_lane_oe_n  = lo_oe_reg;
  assign high_data_lane_out  = hi_out_reg;
  assign high_data_lane_oe_n = hi_oe_reg;
  assign chip_select_a_n     = cs_reg;
  assign chip_select_b_n     = cs_reg;
  assign output_enable_n     = oe_reg;
  assign write_strobe_n      = we_reg;
  assign powerdown_reset_n   = pd_reg;
  assign width_select        = width_reg;
  assign write_protect_n     = wp_reg;

endmodule

`default_nettype wire

//--- fbpi_pkg.sv
package fbpi_pkg;

  // Clock and recovery timing
  localparam int unsigned CLK_PERIOD_NS   = 100;
  localparam int unsigned T_RECOVERY_NS   = 400;
  localparam int unsigned RECOVERY_CYCLES =
    ((T_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
    ((T_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Default phase lengths in clock cycles
  localparam int unsigned SETUP_CYCLES_DEF  = 1;
  localparam int unsigned STROBE_CYCLES_DEF = 2;
  localparam int unsigned HOLD_CYCLES_DEF   = 1;

  // Address field layout of the byte address
  localparam int unsigned ADDR_W       = 21;
  localparam int unsigned BYTE_SEL_BIT = 0;
  localparam int unsigned WORD_LSB     = 1;
  localparam int unsigned WORD_W       = 15;
  localparam int unsigned BLOCK_LSB    = 16;
  localparam int unsigned BLOCK_W      = 5;

  // Data lanes
  localparam int unsigned LANE_W = 8;
  localparam int unsigned DATA_W = 16;

  // Phase timer width
  localparam int unsigned TMR_W = 8;

  // Controller states
  typedef enum logic [2:0] {
    ST_POWERDOWN,
    ST_RECOVER,
    ST_IDLE,
    ST_SETUP,
    ST_STROBE,
    ST_HOLD
  } fbpi_state_type;

endpackage

//--- fbpi_timer_if.sv
`timescale 1ns/1ps
`default_nettype none

// Phase timer request and status
interface fbpi_timer_if;
  import fbpi_pkg::*;
  logic             load;
  logic [TMR_W-1:0] count;
  logic             expired;

  modport ctrl  (output load, output count, input expired);
  modport timer (input load, input count, output expired);
endinterface

`default_nettype wire

//--- fbpi_phase_timer.sv
`timescale 1ns/1ps
`default_nettype none

module fbpi_phase_timer
  import fbpi_pkg::*;
(
  // Clock and reset
  input  wire logic     clock,
  input  wire logic     rst,
  // Timer carrier
  fbpi_timer_if.timer   tmr
);

  logic [TMR_W-1:0] cnt_reg;
  logic [TMR_W-1:0] cnt_next;

  // Load or count down to zero
  always_comb begin
    cnt_next = cnt_reg;
    if (tmr.load) begin
      cnt_next = tmr.count;
    end else if (cnt_reg != '0) begin
      cnt_next = cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  // Expired once the count reaches zero; kept free of load to avoid a loop
  assign tmr.expired = (cnt_reg == '0);

endmodule

`default_nettype wire

//--- fbpi_pkg_end_marker_unused.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

//--- fbpi_props.sv
`timescale 1ns/1ps
`default_nettype none

module fbpi_props
  import fbpi_pkg::*;
(
  // Clock and reset
  input wire logic               clock,
  input wire logic               rst,
  // User side
  input wire logic               cmd_ready,
  input wire logic               rsp_valid,
  input wire logic               device_ready,
  // Flash pins
  input wire logic               byte_lane_select,
  input wire logic [WORD_W-1:0]  word_address,
  input wire logic [BLOCK_W-1:0] block_address,
  input wire logic               low_data_lane_oe_n,
  input wire logic               high_data_lane_oe_n,
  input wire logic               chip_select_a_n,
  input wire logic               chip_select_b_n,
  input wire logic               output_enable_n,
  input wire logic               write_strobe_n,
  input wire logic               powerdown_reset_n,
  input wire logic               width_select
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // Pin relations and cycle timing
  cs_pair_a: assert property (chip_select_a_n == chip_select_b_n)
    else $error("chip selects differ");
  oe_over_we_a: assert property (output_enable_n || write_strobe_n)
    else $error("read and write strobes together");
  lane_float_a: assert property (!output_enable_n |-> low_data_lane_oe_n && high_data_lane_oe_n)
    else $error("host drives lanes during read");
  strobe_sel_a: assert property (!(write_strobe_n && output_enable_n) |-> !chip_select_a_n)
    else $error("strobe without select");
  high_x16_a: assert property (!high_data_lane_oe_n |-> width_select)
    else $error("high lane driven in x8");
  byte_x16_a: assert property (width_select |-> !byte_lane_select)
    else $error("byte select used in x16");
  addr_hold_a: assert property (!write_strobe_n |-> $stable({block_address, word_address}))
    else $error("address moves under strobe");
  strobe_len_a: assert property ($fell(write_strobe_n) |-> !write_strobe_n [*2] ##1 write_strobe_n)
    else $error("strobe width wrong");
  commit_rsp_a: assert property ($rose(write_strobe_n) |-> ##1 rsp_valid)
    else $error("no response after strobe");
  recover_a: assert property ($rose(powerdown_reset_n) |-> !cmd_ready [*4] ##1 cmd_ready)
    else $error("recovery too short");
  pd_ready_a: assert property (!powerdown_reset_n ##1 !powerdown_reset_n |-> !device_ready)
    else $error("ready during power-down");

  // Main scenarios
  cov_write: cover property ($rose(write_strobe_n));
  cov_read: cover property ($fell(output_enable_n));
  cov_x8: cover property (!width_select && !write_strobe_n);
  cov_pd: cover property ($fell(powerdown_reset_n));
endmodule

bind fbpi_host_ctrl fbpi_props u_props (
  .clock, .rst, .cmd_ready, .rsp_valid, .device_ready, .byte_lane_select, .word_address,
  .block_address, .low_data_lane_oe_n, .high_data_lane_oe_n, .chip_select_a_n, .chip_select_b_n,
  .output_enable_n, .write_strobe_n, .powerdown_reset_n, .width_select
);

`default_nettype wire

//--- fbpi_flash_model.sv
`timescale 1ns/1ps
`default_nettype none

module fbpi_flash_model
  import fbpi_pkg::*;
#(
  parameter int unsigned BUSY_NS = 800
)
(
  // Address and control pins
  input wire logic               byte_lane_select,
  input wire logic [WORD_W-1:0]  word_address,
  input wire logic [BLOCK_W-1:0] block_address,
  input wire logic               chip_select_a_n,
  input wire logic               chip_select_b_n,
  input wire logic               output_enable_n,
  input wire logic               write_strobe_n,
  input wire logic               powerdown_reset_n,
  input wire logic               width_select,
  input wire logic               write_protect_n,
  // Data lanes, host half
  input wire logic [LANE_W-1:0]  low_data_lane_out,
  input wire logic               low_data_lane_oe_n,
  input wire logic [LANE_W-1:0]  high_data_lane_out,
  input wire logic               high_data_lane_oe_n,
  // Resolved lanes and status
  output logic [LANE_W-1:0]      low_data_lane_in,
  output logic [LANE_W-1:0]      high_data_lane_in,
  output logic                   ready_busy_pin
);
  logic [DATA_W-1:0] mem [0:1023];
  logic [9:0]        idx;
  logic [DATA_W-1:0] rd;
  logic [LANE_W-1:0] flt;
  logic              pat  = 1'b0;
  logic              busy = 1'b0;
  logic              sel;
  logic              drv;

  // Erased array, changing pattern on floating lanes
  initial for (int i = 0; i < 1024; i++) mem[i] = 16'hffff;
  always #50 pat = !pat;
  assign flt = {4{pat, !pat}};
  // Row bits folded into the column so distinct rows stay apart
  assign idx = {block_address, word_address[4:0] ^ word_address[14:10]};
  assign rd  = mem[idx];
  assign sel = !chip_select_a_n && !chip_select_b_n && powerdown_reset_n;
  assign drv = sel && !output_enable_n;
  assign low_data_lane_in = !low_data_lane_oe_n ? low_data_lane_out :
    drv ? ((!width_select && byte_lane_select) ? rd[15:8] : rd[7:0]) : flt;
  assign high_data_lane_in = !high_data_lane_oe_n ? high_data_lane_out :
    (drv && width_select) ? rd[15:8] : ~flt;
  // capture on strobe rise, block 31 locked
  always @(posedge write_strobe_n) begin
    if (sel && output_enable_n && (write_protect_n || block_address != 5'h1f)) begin
      if (width_select) mem[idx] = {high_data_lane_in, low_data_lane_in};
      else if (byte_lane_select) mem[idx][15:8] = low_data_lane_in;
      else mem[idx][7:0] = low_data_lane_in;
      busy = 1'b1;
      busy <= #(BUSY_NS) 1'b0;
    end
  end
  always @(negedge powerdown_reset_n) busy = 1'b0;
  // status ignores select and output enable
  assign ready_busy_pin = !busy || !powerdown_reset_n;
endmodule

`default_nettype wire

//--- test_flash_bus_pin_interface.sv
`timescale 1ns/1ps
`default_nettype none

module test_flash_bus_pin_interface import fbpi_pkg::*;;
  logic clock = 1'b0, rst = 1'b1, cmd_valid = 1'b0, cmd_write = 1'b0, cmd_byte_mode = 1'b0;
  logic [ADDR_W-1:0] cmd_addr = '0;
  logic [DATA_W-1:0] cmd_wdata = '0, rsp_rdata;
  logic powerdown_req = 1'b0, write_protect_release = 1'b1, cmd_ready, rsp_valid, device_ready;
  logic byte_lane_select, low_data_lane_oe_n, high_data_lane_oe_n, chip_select_a_n, chip_select_b_n;
  logic output_enable_n, write_strobe_n, powerdown_reset_n, width_select, write_protect_n, ready_busy_pin;
  logic [WORD_W-1:0] word_address;
  logic [BLOCK_W-1:0] block_address;
  logic [LANE_W-1:0] low_data_lane_in, low_data_lane_out, high_data_lane_in, high_data_lane_out;
  int n_errors = 0, checks_done = 0;

  // Clock, controller and device
  always #50 clock = ~clock;
  fbpi_host_ctrl uut (.clock, .rst, .cmd_valid, .cmd_write, .cmd_byte_mode, .cmd_addr, .cmd_wdata,
    .cmd_ready, .rsp_valid, .rsp_rdata, .powerdown_req, .write_protect_release, .device_ready,
    .byte_lane_select, .word_address, .block_address, .low_data_lane_in, .low_data_lane_out,
    .low_data_lane_oe_n, .high_data_lane_in, .high_data_lane_out, .high_data_lane_oe_n,
    .chip_select_a_n, .chip_select_b_n, .output_enable_n, .write_strobe_n, .powerdown_reset_n,
    .width_select, .write_protect_n, .ready_busy_pin);
  fbpi_flash_model dev (.byte_lane_select, .word_address, .block_address, .chip_select_a_n,
    .chip_select_b_n, .output_enable_n, .write_strobe_n, .powerdown_reset_n, .width_select,
    .write_protect_n, .low_data_lane_out, .low_data_lane_oe_n, .high_data_lane_out,
    .high_data_lane_oe_n, .low_data_lane_in, .high_data_lane_in, .ready_busy_pin);

  // Comparison and verdict
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Bounded waits on a flag, counting cycles
  task automatic wait_flag(input bit rsp, output int n);
    n = 0;
    while ((rsp ? rsp_valid : cmd_ready) !== 1'b1) begin
      @(negedge clock);
      n++;
      if (n > 60) begin
        n_errors++;
        finish_test();
      end
    end
  endtask
  // One command, driven for one cycle once ready, then wait for its response
  task automatic cmd(input logic w, input logic b, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int n;
    wait_flag(0, n);
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_byte_mode = b;
    cmd_addr = a;
    cmd_wdata = d;
    @(negedge clock);
    cmd_valid = 1'b0;
    wait_flag(1, n);
  endtask

  task automatic t_reset();
    int n;
    @(negedge clock);
    check(powerdown_reset_n, 1'b0);
    check({chip_select_a_n, output_enable_n, write_strobe_n}, 3'h7);
    repeat (9) @(negedge clock);
    rst = 1'b0;
    wait_flag(0, n);
    check(n >= RECOVERY_CYCLES, 1'b1);
    @(negedge clock);
    check(device_ready, 1'b1);
    $display("test reset done");
  endtask
  task automatic t_x16();
    cmd(1, 0, 21'h0_5006, 16'ha55a);
    @(negedge clock);
    check(device_ready, 1'b0);
    cmd(1, 0, 21'h0_6006, 16'h1234);
    cmd(0, 0, 21'h0_5007, 0);
    check(rsp_rdata, 16'ha55a);
    cmd(0, 0, 21'h0_6006, 0);
    check(rsp_rdata, 16'h1234);
    $display("test x16 done");
  endtask
  task automatic t_x8();
    cmd(1, 1, 21'h2_0012, 16'h003c);
    cmd(1, 1, 21'h2_0013, 16'h00c3);
    cmd(0, 0, 21'h2_0012, 0);
    check(rsp_rdata, 16'hc33c);
    cmd(0, 1, 21'h2_0013, 0);
    check(rsp_rdata, 16'h00c3);
    $display("test x8 done");
  endtask
  task automatic t_protect();
    cmd(1, 0, 21'h1f_0000, 16'h0f0f);
    write_protect_release = 1'b0;
    repeat (2) @(negedge clock);
    check(write_protect_n, 1'b0);
    cmd(1, 0, 21'h1f_0000, 16'hf0f0);
    cmd(0, 0, 21'h1f_0000, 0);
    check(rsp_rdata, 16'h0f0f);
    write_protect_release = 1'b1;
    cmd(1, 0, 21'h1f_0000, 16'hf0f0);
    cmd(0, 0, 21'h1f_0000, 0);
    check(rsp_rdata, 16'hf0f0);
    $display("test protect done");
  endtask
  task automatic t_powerdown();
    int n;
    cmd(1, 0, 21'h0_6006, 16'h5678);
    powerdown_req = 1'b1;
    repeat (4) @(negedge clock);
    check({powerdown_reset_n, cmd_ready, device_ready}, 3'h0);
    powerdown_req = 1'b0;
    wait_flag(0, n);
    check(n >= RECOVERY_CYCLES, 1'b1);
    cmd(0, 0, 21'h0_5006, 0);
    check(rsp_rdata, 16'ha55a);
    check(device_ready, 1'b1);
    $display("test powerdown done");
  endtask

  // Main sequence
  initial begin
    t_reset();
    t_x16();
    t_x8();
    t_protect();
    t_powerdown();
    finish_test();
  end
endmodule

`default_nettype wire
